// File: verilog/sbrp_port.v
`timescale 1ns/10ps
`include "sbrp_defines.vh"
module sbrp_port #(
  parameter DEPTH = 8
) (
  input wire mclk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire address_select_strap_i,
  input wire power_good_powerdown_n_i,
  output wire strap_latched_o,
  output wire [DEPTH*8-1:0] cfg_o
);
  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_RX = 6'h08;
  localparam [5:0] S_TX = 6'h10;
  localparam [5:0] S_HACK = 6'h20;

  localparam [1:0] ROLE_IDX = 2'h0;
  localparam [1:0] ROLE_CNT = 2'h1;
  localparam [1:0] ROLE_DAT = 2'h2;

  reg [5:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] role_reg;
  reg rw_reg;
  reg [7:0] index_reg;
  reg [7:0] wr_left_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg sda_oe_reg;
  reg sda_o_reg;
  reg strap_done_reg;
  reg strap_sel_reg;
  wire [DEPTH*8-1:0] mem_flat;
  wire [7:0] cnt_byte;
  wire [7:0] nxt_byte;
  reg wr_en_reg;
  reg [7:0] wr_idx_reg;
  reg [7:0] wr_dat_reg;

  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire [6:0] own_addr;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function [7:0] rd_byte;
    input [7:0] idx;
    input [DEPTH*8-1:0] mem;
    integer k;
    begin
      rd_byte = `SBRP_UNMAPPED;
      for (k = 0; k < DEPTH; k = k + 1) begin
        if (idx == k[7:0]) begin
          rd_byte = mem[k*8 +: 8];
        end
      end
    end
  endfunction

  assign scl_rise = ~scl_prev_reg & scl_i;
  assign scl_fall = scl_prev_reg & ~scl_i;
  // pins are taken as synchronous, so a glitch-free bus is assumed
  assign start_seen = scl_prev_reg & scl_i & sda_prev_reg & ~sda_i;
  assign stop_seen = scl_prev_reg & scl_i & ~sda_prev_reg & sda_i;
  assign own_addr = strap_sel_reg ? `SBRP_ADDR_STRAP1 :
                    `SBRP_ADDR_STRAP0;

  assign sda_o = sda_o_reg;
  assign sda_oe_o = sda_oe_reg;
  assign strap_latched_o = strap_done_reg;
  assign cfg_o = mem_flat;
  assign cnt_byte = rd_byte(`SBRP_CNT_IDX, mem_flat) & `SBRP_CNT_MASK;
  assign nxt_byte = rd_byte(index_reg, mem_flat);

  // -------------------------------------------------------------
  // strap capture
  // -------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      strap_sel_reg <= 1'b0;
    end else if (power_good_powerdown_n_i && !strap_done_reg) begin
      // later power good pulses leave the address alone
      strap_done_reg <= 1'b1;
      strap_sel_reg <= address_select_strap_i;
    end
  end

  // -------------------------------------------------------------
  // register store
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_byte
      // one register per byte, so each flop has a single driver
      reg [7:0] byte_reg;
      assign mem_flat[g*8 +: 8] = byte_reg;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          if (g == `SBRP_CNT_IDX) begin
            byte_reg <= `SBRP_CNT_RST;
          end else begin
            byte_reg <= `SBRP_MEM_RST;
          end
        end else if (wr_en_reg && wr_idx_reg == g) begin
          byte_reg <= wr_dat_reg;
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // bus engine
  // -------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      role_reg <= ROLE_IDX;
      rw_reg <= 1'b0;
      index_reg <= 8'h00;
      wr_left_reg <= 8'h00;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      wr_dat_reg <= 8'h00;
    end else begin
      scl_prev_reg <= scl_i;
      sda_prev_reg <= sda_i;
      wr_en_reg <= 1'b0;
      if (start_seen) begin
        // a repeated start keeps the index for the read phase
        state_reg <= S_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= S_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_i};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `SBRP_BITS_LAST) begin
              bit_cnt_reg <= 4'h0;
              if (strap_done_reg && shift_reg[7:1] == own_addr) begin
                rw_reg <= shift_reg[0];
                role_reg <= ROLE_IDX;
                sda_oe_reg <= 1'b1;
                state_reg <= S_ACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                // count byte comes first, from the count register
                shift_reg <= cnt_byte;
                sda_oe_reg <= ~cnt_byte[7];
                state_reg <= S_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg <= S_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_i};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `SBRP_BITS_LAST) begin
              bit_cnt_reg <= 4'h0;
              sda_oe_reg <= 1'b1;
              state_reg <= S_ACK;
              case (role_reg)
                ROLE_IDX: begin
                  index_reg <= shift_reg;
                  role_reg <= ROLE_CNT;
                end
                ROLE_CNT: begin
                  wr_left_reg <= shift_reg;
                  role_reg <= ROLE_DAT;
                end
                default: begin
                  // bytes past the count are acked but dropped
                  if (wr_left_reg != 8'h00) begin
                    wr_en_reg <= 1'b1;
                    wr_idx_reg <= index_reg;
                    wr_dat_reg <= shift_reg;
                    index_reg <= index_reg + 8'h01;
                    wr_left_reg <= wr_left_reg - 8'h01;
                  end
                end
              endcase
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `SBRP_TX_LAST) begin
                sda_oe_reg <= 1'b0;
                state_reg <= S_HACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= ~shift_reg[6];
              end
            end
          end
          S_HACK: begin
            if (scl_rise && sda_i) begin
              state_reg <= S_IDLE;
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              shift_reg <= nxt_byte;
              sda_oe_reg <= ~nxt_byte[7];
              index_reg <= index_reg + 8'h01;
              state_reg <= S_TX;
            end
          end
          default: begin
            state_reg <= S_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sbrp_port

// File: verilog/sbrp_defines.vh
// What this block does
// - address, index and byte count of a write are each acknowledged
// - X data bytes go to locations N..N+X-1, each acknowledged
// - read opens with start, write address, index; both acknowledged
// - repeated start then read address, no stop; read address acknowledged
// - after read address ack the device first sends the byte count X
// - then data bytes from location N through N+X-1 follow
// - bus address picked by the address select strap level
// - straps sampled on first high level of power good input
`ifndef SBRP_DEFINES_VH
`define SBRP_DEFINES_VH
// ---------------------------------------------------------------
// bus addresses and byte layout
// ---------------------------------------------------------------
`define SBRP_ADDR_STRAP0 7'h68
`define SBRP_ADDR_STRAP1 7'h6a
`define SBRP_BITS_LAST 4'h8
`define SBRP_TX_LAST 4'h7
// ---------------------------------------------------------------
// register store
// ---------------------------------------------------------------
`define SBRP_CNT_IDX 8'h07
`define SBRP_CNT_MASK 8'h1f
`define SBRP_CNT_RST 8'h08
`define SBRP_MEM_RST 8'h00
`define SBRP_UNMAPPED 8'hff
`endif

// File: testbench/sbrp_assertions.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port watch
// ---------------------------------------------------------------
module sbrp_chk #(parameter DEPTH = 8) (
  input wire mclk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire address_select_strap_i,
  input wire power_good_powerdown_n_i,
  input wire strap_latched_o,
  input wire [DEPTH*8-1:0] cfg_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_od; sda_o == 1'b0; endproperty
  property p_quiet; !strap_latched_o |-> !sda_oe_o; endproperty
  property p_frz; !strap_latched_o |=> $stable(cfg_o); endproperty
  property p_hold; strap_latched_o |=> strap_latched_o; endproperty
  property p_lat;
    $rose(strap_latched_o) |-> $past(power_good_powerdown_n_i);
  endproperty
  // sda may only move while scl is low, else a false start or stop
  property p_sclh; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
  property p_cfgl; $changed(cfg_o) |-> !scl_i && !$past(scl_i); endproperty
  property p_ackw; $rose(sda_oe_o) |-> !scl_i ##1 sda_oe_o[*8]; endproperty
  a_od: assert property (p_od) else $error("sda data not low");
  a_quiet: assert property (p_quiet) else $error("drive unlatched");
  a_frz: assert property (p_frz) else $error("store moved unlatched");
  a_hold: assert property (p_hold) else $error("latch dropped");
  a_lat: assert property (p_lat) else $error("latch without power");
  a_sclh: assert property (p_sclh) else $error("sda moved scl high");
  a_cfgl: assert property (p_cfgl) else $error("store moved scl high");
  a_ackw: assert property (p_ackw) else $error("short drive");
  c_ack: cover property ($rose(sda_oe_o));
  c_lat: cover property ($rose(strap_latched_o));
  c_cfg: cover property ($changed(cfg_o));
endmodule // sbrp_chk
bind sbrp_port sbrp_chk #(.DEPTH(DEPTH)) u_chk (.*);

// File: testbench/sbrp_host.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// smbus host model, open drain, pull-up on sda
// ---------------------------------------------------------------
module sbrp_host (
  input wire mclk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task tk;
    repeat (6) @(negedge mclk_i);
  endtask
  task start;
    begin
      sda_low_o = 1'b0;
      tk;
      scl_o = 1'b1;
      tk;
      sda_low_o = 1'b1;
      tk;
      scl_o = 1'b0;
      tk;
    end
  endtask
  task stop;
    begin
      sda_low_o = 1'b1;
      tk;
      scl_o = 1'b1;
      tk;
      sda_low_o = 1'b0;
      tk;
    end
  endtask
  // nine bits, last is the ack slot; host ack 0, nack 1
  task xb(input [8:0] d, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low_o = ~d[i];
        tk;
        scl_o = 1'b1;
        tk;
        r[i] = sda_i;
        tk;
        scl_o = 1'b0;
        tk;
      end
    end
  endtask
endmodule // sbrp_host

// File: testbench/sbrp_port_tb_top.sv
`timescale 1ns/10ps
module sbrp_port_tb_top;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg strap = 1'b1;
  reg pg = 1'b0;
  wire scl, low, oe, sdo, lat;
  wire [63:0] cfg;
  wire sda = ~(low | oe);
  integer error_cnt = 0;
  integer tests_run = 0;
  integer i;
  reg [8:0] r;
  always #2 mclk_i = ~mclk_i;
  sbrp_port #(.DEPTH(8)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
    .address_select_strap_i(strap), .power_good_powerdown_n_i(pg),
    .strap_latched_o(lat), .cfg_o(cfg));
  sbrp_host host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(low));
  task chk(input [63:0] s, input [63:0] e, input string n);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s exp %h got %h", n, e, s);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task wx(input [7:0] b, input a);
    begin
      host.xb({b, 1'b1}, r);
      chk(r[0], !a, "ack");
    end
  endtask
  task rx(input a, input [7:0] e);
    begin
      host.xb({8'hff, a}, r);
      chk(r[8:1], e, "rdata");
    end
  endtask
  task t_lock;
    begin
      host.start;
      wx(8'hd4, 1'b0);
      host.stop;
      chk(cfg, 64'h0800000000000000, "cfg");
      pg = 1'b1;
      i = 0;
      while (lat !== 1'b1 && i < 10) begin
        @(negedge mclk_i);
        i = i + 1;
      end
      chk(lat, 1, "latch");
      chk(sdo, 1'b0, "sda_o");
      if (lat !== 1'b1)
        summarize;
      strap = 1'b0;
      $display("t_lock done");
    end
  endtask
  task t_wr;
    begin
      host.start;
      wx(8'hd4, 1'b1);
      wx(8'h05, 1'b1);
      wx(8'h03, 1'b1);
      wx(8'ha5, 1'b1);
      wx(8'h3c, 1'b1);
      wx(8'h03, 1'b1);
      host.stop;
      chk(cfg, 64'h033ca50000000000, "cfg");
      $display("t_wr done");
    end
  endtask
  task t_rd;
    begin
      host.start;
      wx(8'hd4, 1'b1);
      wx(8'h05, 1'b1);
      host.start;
      wx(8'hd5, 1'b1);
      rx(1'b0, 8'h03);
      rx(1'b0, 8'ha5);
      rx(1'b0, 8'h3c);
      rx(1'b1, 8'h03);
      host.stop;
      $display("t_rd done");
    end
  endtask
  task t_oth;
    begin
      // a second power good pulse must not pick up the new strap level
      pg = 1'b0;
      @(negedge mclk_i);
      pg = 1'b1;
      @(negedge mclk_i);
      host.start;
      wx(8'hd0, 1'b0);
      wx(8'h00, 1'b0);
      wx(8'h01, 1'b0);
      wx(8'h77, 1'b0);
      host.stop;
      chk(cfg, 64'h033ca50000000000, "cfg");
      $display("t_oth done");
    end
  endtask
  initial begin
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b0;
    t_lock;
    t_wr;
    t_rd;
    t_oth;
    summarize;
  end
endmodule // sbrp_port_tb_top
